// ===== include/bcpf_pkg.sv
// constants shared by the commutation, modulator and register logic
package bcpf_pkg;
    // clock and oscillator timing
    localparam int CLK_HZ = 200_000_000;
    localparam int OSC_FREQ_HZ = 25_000;
    localparam int OSC_PERIOD_CYC = CLK_HZ / OSC_FREQ_HZ;
    localparam int RAMP_W = 13;

    // current sense comparator levels in mV
    localparam int CS_W = 8;
    localparam logic [7:0] CS_LOW_MV = 8'h55;
    localparam logic [7:0] CS_NOM_MV = 8'h64;
    localparam logic [7:0] CS_HIGH_MV = 8'h73;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DUTY_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam int ADDR_W = 8;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BRAKE_BIT = 1;
    localparam int CTRL_DIR_BIT = 2;
    localparam int CTRL_SEL60_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h5;
    localparam logic [12:0] DUTY_RST = 13'h1FFF;

    // status register fields
    localparam int ST_VALID_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_OC_BIT = 2;
    localparam int ST_UV_BIT = 3;
    localparam int ST_THERM_BIT = 4;
    localparam int ST_SPEED_BIT = 5;
    localparam int ST_CUR_BIT = 6;
    localparam int ST_TOP_LSB = 8;
    localparam int ST_BOT_LSB = 12;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bcpf_pkg

// ===== logic/bcpf_ramp_osc.sv
// ramp oscillator: sawtooth count and cycle start pulse
module bcpf_ramp_osc #(
    parameter int PERIOD_CYC = bcpf_pkg::OSC_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    output logic [bcpf_pkg::RAMP_W-1:0] ramp,
    output logic cycle_start
);
    import bcpf_pkg::*;

    localparam logic [RAMP_W-1:0] LAST = RAMP_W'(PERIOD_CYC - 1);

    logic [RAMP_W-1:0] ramp_ff;
    logic [RAMP_W-1:0] nxt_ramp;
    logic start_ff;
    logic nxt_start;

    always_comb begin
        nxt_start = (ramp_ff == LAST);
        nxt_ramp = nxt_start ? '0 : ramp_ff + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ramp_ff <= '0;
            start_ff <= 1'b1;
        end else begin
            ramp_ff <= nxt_ramp;
            start_ff <= nxt_start;
        end
    end

    assign ramp = ramp_ff;
    assign cycle_start = start_ff;
endmodule : bcpf_ramp_osc

// ===== logic/bcpf_hall_dec.sv
// rotor sensor decoder: code to top and bottom phase selection
module bcpf_hall_dec (
    input wire logic [2:0] code,
    input wire logic sel60,
    input wire logic dir_fwd,
    output logic valid,
    output logic [2:0] top_on,
    output logic [2:0] bot_on
);
    // phase bits: 2 = A, 1 = B, 0 = C
    logic [2:0] fa;
    logic [2:0] fb;

    always_comb begin
        valid = 1'b1;
        fa = 3'h0;
        fb = 3'h0;
        case ({sel60, code})
            4'h4, 4'hC: begin fa = 3'h4; fb = 3'h1; end
            4'h6, 4'hE: begin fa = 3'h2; fb = 3'h1; end
            4'h2, 4'hF: begin fa = 3'h2; fb = 3'h4; end
            4'h3, 4'hB: begin fa = 3'h1; fb = 3'h4; end
            4'h1, 4'h9: begin fa = 3'h1; fb = 3'h2; end
            4'h5, 4'h8: begin fa = 3'h4; fb = 3'h2; end
            default: valid = 1'b0;
        endcase
        // reverse swaps top and bottom phases
        top_on = dir_fwd ? fa : fb;
        bot_on = dir_fwd ? fb : fa;
    end
endmodule : bcpf_hall_dec

// ===== logic/bcpf_commutator.sv
// three phase commutation, dual latch modulator and protection with axi4-lite registers
// How it works
// - current sense reads 0 under 85 mV, 1 over 115 mV, 100 mV nominal
// - fault and top drive outputs are active low
// - phasing select 1 uses the 60 degree table, 0 the 120 degree table
// - invalid code without brake: all drives off, fault low
// - invalid code with brake: tops off, bottoms on, fault low
// - valid code, brake, enable: tops off, bottoms on, fault high
// - valid code, brake, no enable: tops off, bottoms on, fault low
// - valid code, no brake, no enable: all drives off, fault low
// - valid, enabled, no brake, overcurrent: bottoms off, fault low
// - each oscillator cycle start sets both modulator latches
// - ramp above error level clears the speed latch, ending bottom conduction
// - speed modulation chops bottom drives only, never top drives
// - overcurrent clears current latch, switch stays off for the ramp period
// - at most one conduction pulse per oscillator cycle
// - any undervoltage flag: fault, tops off, bottoms held low
// - fault on invalid code, disable, overcurrent, undervoltage or overtemperature
// - brake overrides direction, enable, sensor code and current sense
// - bottoms brake only after all three top drives are off
// - thermal shutdown acts as enable held low
// - enable low without brake: tops off, bottoms low, fault active
module bcpf_commutator #(
    parameter int OSC_PERIOD_CYC = bcpf_pkg::OSC_PERIOD_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [2:0] SENSOR_CODE,
    input wire logic SEL_60DEG,
    input wire logic DIR_FWD,
    input wire logic OUTPUT_ENABLE,
    input wire logic BRAKE,
    input wire logic [bcpf_pkg::CS_W-1:0] CURRENT_SENSE_MV,
    input wire logic UV_LOGIC_SUPPLY,
    input wire logic UV_DRIVE_SUPPLY,
    input wire logic UV_REFERENCE,
    input wire logic THERMAL_SHUTDOWN,
    output logic [2:0] TOP_DRIVE_N,
    output logic [2:0] BOTTOM_DRIVE,
    output logic FAULT_N,
    input wire logic [bcpf_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [bcpf_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import bcpf_pkg::*;

    // oscillator and decoder
    logic [RAMP_W-1:0] ramp;
    logic cycle_start;
    logic valid;
    logic [2:0] top_on;
    logic [2:0] bot_on;
    logic [3:0] ctrl_ff;
    logic [3:0] nxt_ctrl;
    logic [RAMP_W-1:0] duty_ff;
    logic [RAMP_W-1:0] nxt_duty;

    bcpf_ramp_osc #(.PERIOD_CYC(OSC_PERIOD_CYC)) u_osc (
        .clk(CLK),
        .resetn(RESETN),
        .ramp(ramp),
        .cycle_start(cycle_start)
    );

    bcpf_hall_dec u_dec (
        .code(SENSOR_CODE),
        .sel60(SEL_60DEG | ctrl_ff[CTRL_SEL60_BIT]),
        .dir_fwd(DIR_FWD ^ ctrl_ff[CTRL_DIR_BIT]),
        .valid(valid),
        .top_on(top_on),
        .bot_on(bot_on)
    );

    // protection and modulator state
    logic oc_ff;
    logic nxt_oc;
    logic speed_ff;
    logic nxt_speed;
    logic cur_ff;
    logic nxt_cur;
    logic [2:0] top_n_ff;
    logic [2:0] nxt_top_n;
    logic [2:0] bot_ff;
    logic [2:0] nxt_bot;
    logic fault_n_ff;
    logic nxt_fault_n;
    logic en_eff;
    logic brake_eff;
    logic uv_any;

    always_comb begin
        nxt_oc = oc_ff;
        if (CURRENT_SENSE_MV > CS_HIGH_MV) begin
            nxt_oc = 1'b1;
        end else if (CURRENT_SENSE_MV < CS_LOW_MV) begin
            nxt_oc = 1'b0;
        end
        // set both latches at cycle start
        // ramp past error level ends pulse
        // no re-set until next cycle start
        nxt_speed = speed_ff;
        nxt_cur = cur_ff;
        if (cycle_start) begin
            nxt_speed = 1'b1;
            nxt_cur = 1'b1;
        end else begin
            if (ramp > duty_ff) begin
                nxt_speed = 1'b0;
            end
            // current latch held off for the ramp
            if (oc_ff) begin
                nxt_cur = 1'b0;
            end
        end
        en_eff = OUTPUT_ENABLE & ctrl_ff[CTRL_EN_BIT] & ~THERMAL_SHUTDOWN;
        brake_eff = BRAKE | ctrl_ff[CTRL_BRAKE_BIT];
        uv_any = UV_LOGIC_SUPPLY | UV_DRIVE_SUPPLY | UV_REFERENCE;
        nxt_top_n = 3'h7;
        nxt_bot = 3'h0;
        if (uv_any) begin
            nxt_bot = 3'h0;
        end else if (brake_eff) begin
            nxt_bot = (&top_n_ff) ? 3'h7 : 3'h0;
        end else if (valid && en_eff) begin
            nxt_top_n = ~top_on;
            nxt_bot = (speed_ff & cur_ff & ~oc_ff) ? bot_on : 3'h0;
        end
        nxt_fault_n = ~(~valid | ~en_eff | oc_ff | uv_any);
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            oc_ff <= 1'b0;
            speed_ff <= 1'b0;
            cur_ff <= 1'b0;
            top_n_ff <= 3'h7;
            bot_ff <= 3'h0;
            fault_n_ff <= 1'b0;
        end else begin
            oc_ff <= nxt_oc;
            speed_ff <= nxt_speed;
            cur_ff <= nxt_cur;
            top_n_ff <= nxt_top_n;
            bot_ff <= nxt_bot;
            fault_n_ff <= nxt_fault_n;
        end
    end

    assign TOP_DRIVE_N = top_n_ff;
    assign BOTTOM_DRIVE = bot_ff;
    // fault pin feeds external delay network
    assign FAULT_N = fault_n_ff;

    // axi4-lite slave
    logic awready_ff;
    logic nxt_awready;
    logic wready_ff;
    logic nxt_wready;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [ADDR_W-1:0] nxt_awaddr;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic [3:0] wstrb_ff;
    logic [3:0] nxt_wstrb;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;
    logic arready_ff;
    logic nxt_arready;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;
    logic [31:0] status;

    always_comb begin
        status = 32'h0;
        status[ST_VALID_BIT] = valid;
        status[ST_FAULT_BIT] = ~fault_n_ff;
        status[ST_OC_BIT] = oc_ff;
        status[ST_UV_BIT] = uv_any;
        status[ST_THERM_BIT] = THERMAL_SHUTDOWN;
        status[ST_SPEED_BIT] = speed_ff;
        status[ST_CUR_BIT] = cur_ff;
        status[ST_TOP_LSB +: 3] = ~top_n_ff;
        status[ST_BOT_LSB +: 3] = bot_ff;

        nxt_awready = awready_ff;
        nxt_wready = wready_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_duty = duty_ff;
        if (S_AXI_AWVALID && awready_ff) begin
            nxt_awaddr = S_AXI_AWADDR;
            nxt_awready = 1'b0;
        end
        if (S_AXI_WVALID && wready_ff) begin
            nxt_wdata = S_AXI_WDATA;
            nxt_wstrb = S_AXI_WSTRB;
            nxt_wready = 1'b0;
        end
        // both halves held, response not yet issued
        if (!awready_ff && !wready_ff && !bvalid_ff) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (awaddr_ff)
                CTRL_OFS: begin
                    if (wstrb_ff[0]) begin
                        nxt_ctrl = wdata_ff[3:0];
                    end
                end
                DUTY_OFS: begin
                    if (wstrb_ff[0]) begin
                        nxt_duty[7:0] = wdata_ff[7:0];
                    end
                    if (wstrb_ff[1]) begin
                        nxt_duty[RAMP_W-1:8] = wdata_ff[RAMP_W-1:8];
                    end
                end
                STATUS_OFS: nxt_bresp = RESP_OKAY;
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && S_AXI_BREADY) begin
            nxt_bvalid = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready = 1'b1;
        end

        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (S_AXI_ARVALID && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            case (S_AXI_ARADDR)
                CTRL_OFS: nxt_rdata = {28'h0, ctrl_ff};
                DUTY_OFS: nxt_rdata = {19'h0, duty_ff};
                STATUS_OFS: nxt_rdata = status;
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_ff && S_AXI_RREADY) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
            ctrl_ff <= CTRL_RST;
            duty_ff <= DUTY_RST;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            ctrl_ff <= nxt_ctrl;
            duty_ff <= nxt_duty;
        end
    end

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY = wready_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;
endmodule : bcpf_commutator

// ===== verification/bcpf_commutator_chk.sv
// checker on the commutator top ports
module bcpf_chk (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [2:0] SENSOR_CODE,
    input wire logic SEL_60DEG,
    input wire logic OUTPUT_ENABLE,
    input wire logic BRAKE,
    input wire logic [bcpf_pkg::CS_W-1:0] CURRENT_SENSE_MV,
    input wire logic UV_LOGIC_SUPPLY,
    input wire logic UV_DRIVE_SUPPLY,
    input wire logic UV_REFERENCE,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic [2:0] TOP_DRIVE_N,
    input wire logic [2:0] BOTTOM_DRIVE,
    input wire logic FAULT_N,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY
);
    import bcpf_pkg::*;
    logic nxt_run;
    logic run_ff;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // skips the first edge after release
    always_comb nxt_run = RESETN;
    always_ff @(posedge CLK) run_ff <= nxt_run;
    a_brake_tops_off: assert property (run_ff && BRAKE |=> TOP_DRIVE_N == 3'h7)
        else $error("tops not off under brake");
    a_brake_after_tops: assert property (run_ff && BOTTOM_DRIVE == 3'h7 && $past(BOTTOM_DRIVE) != 3'h7
        |-> $past(TOP_DRIVE_N) == 3'h7) else $error("brake before tops off");
    a_uv_lockout: assert property (run_ff && (UV_LOGIC_SUPPLY || UV_DRIVE_SUPPLY || UV_REFERENCE)
        |=> TOP_DRIVE_N == 3'h7 && BOTTOM_DRIVE == 3'h0 && !FAULT_N) else $error("undervoltage not locked");
    a_therm_fault: assert property (run_ff && THERMAL_SHUTDOWN |=> !FAULT_N && TOP_DRIVE_N == 3'h7)
        else $error("thermal not shut down");
    a_disable_coast: assert property (run_ff && !OUTPUT_ENABLE && !BRAKE
        |=> !FAULT_N && TOP_DRIVE_N == 3'h7 && BOTTOM_DRIVE == 3'h0) else $error("disable not coasting");
    a_oc_cuts_bottom: assert property ((run_ff && CURRENT_SENSE_MV > CS_HIGH_MV && !BRAKE)[*2]
        |=> BOTTOM_DRIVE == 3'h0 && !FAULT_N) else $error("overcurrent not cut");
    a_invalid_fault: assert property (run_ff && SEL_60DEG && (SENSOR_CODE == 3'h2 || SENSOR_CODE == 3'h5)
        |=> !FAULT_N) else $error("invalid code without fault");
    a_one_top_bot: assert property (FAULT_N && TOP_DRIVE_N != 3'h7 |-> $onehot(~TOP_DRIVE_N)
        && $onehot0(BOTTOM_DRIVE) && (~TOP_DRIVE_N & BOTTOM_DRIVE) == 3'h0) else $error("bad phase pair");
    a_tops_no_chop: assert property (run_ff && FAULT_N && BOTTOM_DRIVE == 3'h0 && $past(BOTTOM_DRIVE) != 3'h0
        && !$past(BRAKE) && !$past(BRAKE, 2) && $past(SENSOR_CODE) == $past(SENSOR_CODE, 2)
        |-> TOP_DRIVE_N == $past(TOP_DRIVE_N) && TOP_DRIVE_N != 3'h7) else $error("top chopped");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered");
    a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped");
endmodule : bcpf_chk

bind bcpf_commutator bcpf_chk u_chk (.CLK(CLK), .RESETN(RESETN), .SENSOR_CODE(SENSOR_CODE),
    .SEL_60DEG(SEL_60DEG), .OUTPUT_ENABLE(OUTPUT_ENABLE), .BRAKE(BRAKE), .CURRENT_SENSE_MV(CURRENT_SENSE_MV),
    .UV_LOGIC_SUPPLY(UV_LOGIC_SUPPLY), .UV_DRIVE_SUPPLY(UV_DRIVE_SUPPLY), .UV_REFERENCE(UV_REFERENCE),
    .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .TOP_DRIVE_N(TOP_DRIVE_N), .BOTTOM_DRIVE(BOTTOM_DRIVE),
    .FAULT_N(FAULT_N), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY));

// ===== verification/bcpf_motor_model.sv
// motor model: rotor sensors, sense resistor, delayed shutdown network
module bcpf_motor_model #(
    parameter int DLY_CYC = 6
) (
    input wire logic clk,
    input wire logic [2:0] pos,
    input wire logic sel60,
    input wire logic [2:0] bottom,
    input wire logic load_hi,
    input wire logic fault_n,
    input wire logic en_req,
    input wire logic latch_mode,
    output logic [2:0] code,
    output logic [7:0] cs_mv,
    output logic enable
);
    localparam logic [2:0] C60 [8] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0, 3'h2, 3'h5};
    localparam logic [2:0] C120 [8] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5, 3'h0, 3'h7};
    logic [3:0] dly_ff;
    logic [3:0] nxt_dly;
    // positions 6 and 7 give invalid codes
    assign code = sel60 ? C60[pos] : C120[pos];
    // current only through a conducting bottom switch
    assign cs_mv = (load_hi && bottom != 3'h0) ? 8'h78 : 8'h1E;
    always_comb nxt_dly = !latch_mode ? 4'h0 : (!fault_n && dly_ff != 4'(DLY_CYC)) ? dly_ff + 4'h1 : dly_ff;
    always_ff @(posedge clk) dly_ff <= nxt_dly;
    assign enable = en_req && dly_ff != 4'(DLY_CYC);
endmodule : bcpf_motor_model

// ===== verification/bcpf_commutator_test.sv
// self-checking bench for the commutator and motor model
module bcpf_commutator_test;
    timeunit 1ns;
    timeprecision 100ps;
    import bcpf_pkg::*;
    localparam logic [2:0] TF [6] = '{3'h3, 3'h5, 3'h5, 3'h6, 3'h6, 3'h3};
    localparam logic [2:0] BF [6] = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h2, 3'h2};
    localparam logic [2:0] TR [6] = '{3'h6, 3'h6, 3'h3, 3'h3, 3'h5, 3'h5};
    localparam logic [2:0] BR [6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h4};
    localparam logic [5:0] PROT [6] = '{6'h00, 6'h20, 6'h18, 6'h31, 6'h32, 6'h34};
    localparam logic [6:0] PEXP [6] = '{7'h70, 7'h7E, 7'h70, 7'h70, 7'h70, 7'h70};
    logic clk, resetn, sel60, dir_fwd, en_req, brake, load_hi, latch_mode, therm, enable, fault_n;
    logic [2:0] pos, uv, code, top_n, bot;
    logic [7:0] cs_mv, awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, kind;
    logic [15:0] got;
    logic [33:0] q_rd[$];
    logic [1:0] q_b[$];
    logic [15:0] q_obs[$];
    int errors, tests_run, cyc;

    bcpf_commutator #(.OSC_PERIOD_CYC(16)) dut (.CLK(clk), .RESETN(resetn), .SENSOR_CODE(code),
        .SEL_60DEG(sel60), .DIR_FWD(dir_fwd), .OUTPUT_ENABLE(enable), .BRAKE(brake), .CURRENT_SENSE_MV(cs_mv),
        .UV_LOGIC_SUPPLY(uv[0]), .UV_DRIVE_SUPPLY(uv[1]), .UV_REFERENCE(uv[2]), .THERMAL_SHUTDOWN(therm),
        .TOP_DRIVE_N(top_n), .BOTTOM_DRIVE(bot), .FAULT_N(fault_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    bcpf_motor_model #(.DLY_CYC(6)) u_motor (.clk(clk), .pos(pos), .sel60(sel60), .bottom(bot),
        .load_hi(load_hi), .fault_n(fault_n), .en_req(en_req), .latch_mode(latch_mode), .code(code),
        .cs_mv(cs_mv), .enable(enable));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [6:0] exp_drv(input logic [2:0] p, input logic f, input logic b);
        if (p > 3'h5) return b ? 7'h7E : 7'h70;
        if (b) return 7'h7F;
        return f ? {TF[p], BF[p], 1'b1} : {TR[p], BR[p], 1'b1};
    endfunction : exp_drv

    task automatic bad(input string m);
        $display("BAD %0t %s", $time, m);
        errors++;
    endtask : bad

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic note(input logic [1:0] k, input logic [15:0] e, input logic [15:0] g);
        q_obs.push_back(e);
        got <= g;
        kind <= k;
        @(posedge clk);
        kind <= 2'h0;
        @(posedge clk);
    endtask : note

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w, b;
        q_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge clk);
            aw = awready && awvalid;
            w = wready && wvalid;
            b = bvalid;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ar, r;
        q_rd.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r = 1'b0;
        while (!r) begin
            @(negedge clk);
            ar = arready && arvalid;
            r = rvalid;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end
        @(posedge clk);
    endtask : rd

    // monitor: compares each result with the oldest expected value in its queue
    always @(posedge clk) begin
        if (rvalid && rready) begin
            tests_run++;
            if (q_rd.size() == 0 || {rresp, rdata} !== q_rd[0]) bad("read word");
            if (q_rd.size() != 0) void'(q_rd.pop_front());
        end
        if (bvalid && bready) begin
            tests_run++;
            if (q_b.size() == 0 || bresp !== q_b[0]) bad("write response");
            if (q_b.size() != 0) void'(q_b.pop_front());
        end
        if (kind != 2'h0) begin
            tests_run++;
            if (q_obs.size() == 0 || q_obs[0] !== (kind == 2'h1 ? {9'h0, top_n, bot, fault_n} : got)) bad("output");
            if (q_obs.size() != 0) void'(q_obs.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad("timeout");
            conclude();
        end
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        logic [31:0] rnd;
        logic [15:0] n, tc;
        logic pb;
        {resetn, awvalid, wvalid, bready, arvalid, rready, brake, load_hi, latch_mode, therm, kind} = '0;
        {sel60, dir_fwd, en_req} = 3'h7;
        {pos, uv, awaddr, araddr, wdata, got} = '0;
        seed = 32'h4AC5E1F4;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        note(2'h1, 16'h70, 16'h0);
        rd(CTRL_OFS, {RESP_OKAY, 28'h0, CTRL_RST});
        rd(DUTY_OFS, {RESP_OKAY, 19'h0, DUTY_RST});
        rd(8'h0C, {RESP_SLVERR, 32'h0});
        wr(8'h0C, 32'h1, RESP_SLVERR);
        wr(STATUS_OFS, 32'hFF, RESP_OKAY);
        wr(CTRL_OFS, 32'h1, RESP_OKAY);
        rd(CTRL_OFS, {RESP_OKAY, 32'h1});
        $display("registers done");
        for (int i = 0; i < 32; i++) begin
            rnd = xs();
            pos <= i[2:0];
            sel60 <= i[3];
            dir_fwd <= i[4];
            brake <= rnd[0];
            repeat (4) @(posedge clk);
            note(2'h1, {9'h0, exp_drv(i[2:0], i[4], rnd[0])}, 16'h0);
        end
        $display("commutation done");
        {pos, sel60, dir_fwd} <= 5'h01;
        for (int k = 0; k < 6; k++) begin
            {brake, en_req, therm, uv} <= PROT[k];
            repeat (4) @(posedge clk);
            note(2'h1, {9'h0, PEXP[k]}, 16'h0);
            {brake, en_req, therm, uv} <= 6'h10;
            repeat (4) @(posedge clk);
        end
        $display("protection done");
        wr(DUTY_OFS, 32'h7, RESP_OKAY);
        repeat (20) @(posedge clk);
        {n, tc} = '0;
        repeat (16) begin
            @(negedge clk);
            n = n + 16'(bot != 3'h0);
            tc = tc + 16'(top_n !== 3'h3);
        end
        @(posedge clk);
        note(2'h2, 16'h1, 16'(n >= 16'h7 && n <= 16'h9));
        note(2'h2, 16'h0, tc);
        $display("modulator done");
        wr(DUTY_OFS, 32'h1FFF, RESP_OKAY);
        load_hi <= 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        pb = bot[0];
        {n, tc} = '0;
        repeat (32) begin
            @(negedge clk);
            n = n + 16'(bot[0] && !pb);
            tc = tc + 16'(!fault_n);
            pb = bot[0];
        end
        @(posedge clk);
        note(2'h2, 16'h2, n);
        note(2'h2, 16'h1, 16'(tc != 16'h0));
        $display("current limit done");
        latch_mode <= 1'b1;
        repeat (150) @(posedge clk);
        load_hi <= 1'b0;
        repeat (20) @(posedge clk);
        note(2'h1, 16'h70, 16'h0);
        latch_mode <= 1'b0;
        repeat (6) @(posedge clk);
        note(2'h1, 16'h33, 16'h0);
        $display("latched shutdown done");
        rd(STATUS_OFS, {RESP_OKAY, 32'h1461});
        wr(CTRL_OFS, 32'h5, RESP_OKAY);
        repeat (4) @(posedge clk);
        note(2'h1, {9'h0, exp_drv(3'h0, 1'b0, 1'b0)}, 16'h0);
        $display("control done");
        conclude();
    end
endmodule : bcpf_commutator_test
